// [shared/cgc_pkg.sv]
// Purpose: Constants for the conference tone and gain control block
// Assumes: 25 MHz system clock, 9-bit register address, 8-bit data
// Notes:   Offsets are word addresses on the plain register port
package cgc_pkg;
  localparam int          AW          = 9;
  localparam logic [8:0]  A_BRIDGE    = 9'h100;
  localparam logic [8:0]  A_IRQST     = 9'h101;
  localparam logic [8:0]  A_IRQMASK   = 9'h102;
  localparam logic [8:0]  A_OVFID     = 9'h103;
  localparam logic [8:0]  A_PARTY0    = 9'h110;
  localparam logic [8:0]  A_CMH0      = 9'h060;
  localparam logic [8:0]  A_CML0      = 9'h160;
  localparam int          PARTIES     = 15;
  localparam int          CONFS       = 5;
  localparam logic [3:0]  TONE_ENTRY  = 4'hF;
  // Bridge control fields
  localparam int          BC_ON       = 0;
  localparam int          BC_PER      = 1;
  localparam int          BC_LAW      = 4;
  localparam int          BC_RST      = 7;
  localparam logic [7:0]  BC_RESET    = 8'h00;
  localparam int          IRQ_OVF     = 1;
  localparam int          MASK_OVF    = 1;
  localparam logic [7:0]  MASK_RESET  = 8'h00;
  // Party control fields
  localparam int          PC_LEAD     = 3;
  localparam int          PC_TONE     = 4;
  localparam int          PC_GAIN     = 5;
  // Connect map high fields
  localparam int          CMH_INV     = 5;
  localparam int          CMH_DRIVE   = 6;
  localparam int          CMH_DELAY   = 7;
  localparam logic [4:0]  LVL_UNITY   = 5'h03;
  localparam logic [4:0]  LVL_MUTE    = 5'h1F;
  localparam logic [12:0] CLIP_MU     = 13'd8031;
  localparam logic [12:0] CLIP_A      = 13'd4032;
  localparam int          SUM_MAX     = 8191;
  localparam int          SUM_MIN     = -8192;
  // Q8 gain mantissas for one 6 dB octave, and 3 dB conference steps
  localparam logic [5:0][9:0] LVL_MANT =
    {10'd144, 10'd161, 10'd181, 10'd203, 10'd228, 10'd256};
  localparam logic [3:0][9:0] CONF_GAIN =
    {10'd91, 10'd128, 10'd181, 10'd256};
  localparam int          CLK_NS      = 40;
  localparam int          TONE_STEP_NS = 125000000;
  localparam int          TONE_STEP_CYC = TONE_STEP_NS / CLK_NS;
endpackage : cgc_pkg

// [rtl/cgc_conference_gain.sv]
// Purpose: Conference bridge control, tone insertion and PCM gain path
// Assumes: Samples arrive one per cycle, frameStart marks frame edges
// Notes:   Functional notes below
// Functional notes
// - Joining party with tone flag adds tone to its conference output
// - Any buffer location may be tone source; its PCM is added
// - Tone period 0.125 s to 1.0 s, timed from party write
// - Detect 14-bit conference sum overflow and which conference
// - Overflow sets status bit, raises interrupt, captures conference
// - Status read clears flag; no new interrupt while flag set
// - Mask bit 1 gates interrupt but never blocks ID capture
// - Captured ID held until read, bridge reset or device reset
// - Same overflow limit both laws; clip to 8031 or 4032
// - Lead party write drops older parties of that conference
// - Resets clear every party control, conference IDs go null
// - Conference ID 0 disconnects; host clears drive_slot
// - Channel gain +3 to -27 dB in 1 dB steps plus mute
// - Conference in and out gain 0 to -9 dB in 3 dB steps
// - PCM channel at 0 dB bypasses; else expand, scale, recompress to 8 bit
// - Tone and bridge kept linear, then channel gain and compress
// - 15 parties, 5 conferences, output excludes own contribution
// - Bridge inputs from map entries 60-6E, outputs per party
// - Delay mode chosen per connection by delay_select
`timescale 1ns/1ps
module cgc_conference_gain #(
  parameter int TONE_STEP = cgc_pkg::TONE_STEP_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic [cgc_pkg::AW-1:0] addr,
  input  wire logic [7:0]           wrData,
  input  wire logic                 wrEn,
  input  wire logic                 rdEn,
  output logic      [7:0]           rdData,
  output logic                      irq,
  input  wire logic                 frameStart,
  input  wire logic                 inValid,
  input  wire logic [3:0]           inParty,
  input  wire logic [7:0]           inPcm,
  input  wire logic                 toneValid,
  input  wire logic [7:0]           tonePcm,
  output logic      [7:0]           toneSrcAddr,
  input  wire logic                 outReq,
  input  wire logic [3:0]           outParty,
  output logic                      outValid,
  output logic signed [13:0]        outLin,
  input  wire logic                 chReq,
  input  wire logic [4:0]           chLevel,
  input  wire logic                 chLinear,
  input  wire logic [13:0]          chData,
  output logic                      chValid,
  output logic      [7:0]           chPcm,
  output logic      [15:0]          driveSlot,
  output logic      [15:0]          delayConst
);
  import cgc_pkg::*;

  function automatic logic signed [13:0] expand(input logic [7:0] c);
    logic [12:0] m;
    m = (c[6:4] == 3'd0) ? {8'd0, c[3:0], 1'b1}
      : 13'({7'd0, 1'b1, c[3:0], 1'b1} << (c[6:4] - 3'd1));
    return c[7] ? -$signed({1'b0, m}) : $signed({1'b0, m});
  endfunction : expand

  function automatic logic [7:0] compress(input logic signed [13:0] v,
                                          input logic [12:0] lim);
    logic [13:0] a;
    logic [12:0] m;
    logic [2:0]  s;
    logic [3:0]  t;
    a = v[13] ? 14'(-v) : 14'(v);
    m = (a > {1'b0, lim}) ? lim : a[12:0];
    s = 3'd0;
    for (int i = 1; i < 8; i++) begin
      if (m >= 13'(32 << (i - 1))) s = 3'(i);
    end
    t = (s == 3'd0) ? m[4:1] : 4'(m >> s);
    if (m[12]) t = 4'hF;
    return {v[13], s, t};
  endfunction : compress

  function automatic logic signed [13:0] clip14(input logic signed [17:0] x);
    if (x > SUM_MAX) return 14'sh1FFF;
    if (x < SUM_MIN) return 14'sh2000;
    return x[13:0];
  endfunction : clip14

  function automatic logic signed [15:0] scale(input logic signed [13:0] x,
                                               input logic [9:0] g);
    logic signed [24:0] p;
    p = x * $signed({1'b0, g});
    return p[23:8];
  endfunction : scale

  function automatic logic [9:0] lvlGain(input logic [4:0] lv);
    logic [5:0] k;
    k = 6'(lv) + 6'd3;
    return 10'({LVL_MANT[k % 6], 1'b0} >> (k / 6));
  endfunction : lvlGain

  ////////////////////////////////////////////////////////////////////////
  // Register state and decode
  logic [7:0]         bridgeCtrl;
  logic [7:0]         irqMask;
  logic               ovfFlag;
  logic [2:0]         ovfId;
  logic [6:0]         partyCtrl [PARTIES];
  logic [7:0]         connect_map_low [16];
  logic [7:0]         connect_map_high [16];
  logic signed [17:0] acc [CONFS];
  logic signed [17:0] confSum [CONFS];
  logic signed [13:0] own [PARTIES];
  logic signed [13:0] ownF [PARTIES];
  logic signed [13:0] toneLin;
  logic [31:0]        toneCnt [CONFS];
  logic [CONFS-1:0]   toneAct;
  logic [CONFS-1:0]   ovfVec;
  logic [2:0]         newId;

  wire       bridgeOn  = bridgeCtrl[BC_ON];
  wire       hitParty  = addr >= A_PARTY0 && addr < A_PARTY0 + 9'd15;
  wire [3:0] wIdx      = addr[3:0];
  wire       hitCml    = addr[8:4] == A_CML0[8:4];
  wire       hitCmh    = addr[8:4] == A_CMH0[8:4];
  wire       partyWr   = wrEn && hitParty;
  wire [2:0] wrId      = wrData[2:0];
  wire       leadWr    = partyWr && wrData[PC_LEAD] && wrId != 3'd0;
  wire       blkClr    = wrEn && addr == A_BRIDGE && wrData[BC_RST];
  wire       irqRd     = rdEn && addr == A_IRQST;
  wire       idRd      = rdEn && addr == A_OVFID;
  wire       ovfEvent  = frameStart && bridgeOn && |ovfVec;
  wire [12:0] lawLim   = bridgeCtrl[BC_LAW] ? CLIP_A : CLIP_MU;

  always_comb begin
    newId = 3'd0;
    for (int c = CONFS - 1; c >= 0; c--) begin
      if (ovfVec[c]) newId = 3'(c + 1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bridgeCtrl <= BC_RESET;
      irqMask    <= MASK_RESET;
    end else if (wrEn) begin
      if (addr == A_BRIDGE) bridgeCtrl <= {1'b0, wrData[6:0]};
      else if (addr == A_IRQMASK) irqMask <= wrData;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ovfFlag <= 1'b0;
      ovfId   <= 3'd0;
    end else begin
      ovfFlag <= ovfEvent | (ovfFlag & ~irqRd);
      if (blkClr) ovfId <= 3'd0;
      else if (ovfEvent && (ovfId == 3'd0 || idRd)) ovfId <= newId;
      else if (idRd) ovfId <= 3'd0;
    end
  end

  assign irq = ovfFlag & irqMask[MASK_OVF];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        connect_map_low[i] <= 8'h00;
        connect_map_high[i] <= 8'h00;
      end
    end else if (wrEn && hitCml) begin
      connect_map_low[wIdx] <= wrData;
    end else if (wrEn && hitCmh) begin
      connect_map_high[wIdx] <= wrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Party control, tone timers, accumulators
  wire [2:0]  inId    = partyCtrl[inParty][2:0];
  wire [7:0]  inCmh   = connect_map_high[inParty];
  wire signed [15:0] inScaled = scale(expand(inPcm), CONF_GAIN[inCmh[1:0]]);
  wire signed [13:0] inGained = inCmh[CMH_INV] ? -inScaled[13:0]
                                               : inScaled[13:0];
  wire        inOk    = inValid && bridgeOn && inParty < 4'd15;

  genvar p, c;
  generate
    for (p = 0; p < PARTIES; p++) begin : g_party
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) partyCtrl[p] <= 7'd0;
        else if (blkClr) partyCtrl[p] <= 7'd0;
        else if (partyWr && wIdx == 4'(p)) partyCtrl[p] <= wrData[6:0];
        else if (leadWr && partyCtrl[p][2:0] == wrId)
          partyCtrl[p] <= 7'd0;
      end
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          own[p]  <= 14'sd0;
          ownF[p] <= 14'sd0;
        end else begin
          if (inOk && inParty == 4'(p)) own[p] <= inGained;
          if (frameStart) ownF[p] <= own[p];
        end
      end
    end
    for (c = 0; c < CONFS; c++) begin : g_conf
      wire toneGo = partyWr && bridgeOn && wrData[PC_TONE]
                    && wrId == 3'(c + 1);
      assign ovfVec[c] = acc[c] > SUM_MAX || acc[c] < SUM_MIN;
      assign toneAct[c] = toneCnt[c] != 32'd0;
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) toneCnt[c] <= 32'd0;
        else if (blkClr) toneCnt[c] <= 32'd0;
        else if (toneGo)
          toneCnt[c] <= 32'(({29'd0, bridgeCtrl[BC_PER +: 3]} + 32'd1)
                            * TONE_STEP);
        else if (toneAct[c]) toneCnt[c] <= toneCnt[c] - 32'd1;
      end
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          acc[c]     <= 18'sd0;
          confSum[c] <= 18'sd0;
        end else if (blkClr) begin
          acc[c]     <= 18'sd0;
          confSum[c] <= 18'sd0;
        end else if (frameStart) begin
          acc[c]     <= 18'sd0;
          confSum[c] <= acc[c];
        end else if (inOk && inId == 3'(c + 1)) begin
          acc[c] <= acc[c] + 18'(inGained);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) toneLin <= 14'sd0;
    else if (toneValid)
      toneLin <= clip14(18'(scale(expand(tonePcm),
                                  lvlGain(connect_map_high[TONE_ENTRY][4:0]))));
  end

  assign toneSrcAddr = connect_map_low[TONE_ENTRY];

  ////////////////////////////////////////////////////////////////////////
  // Bridge output and channel gain stage
  wire [6:0]  oPc   = partyCtrl[outParty];
  wire [2:0]  oIdx  = (oPc[2:0] == 3'd0 || oPc[2:0] > 3'd5) ? 3'd0
                      : oPc[2:0] - 3'd1;
  wire signed [13:0] oTone = (toneAct[oIdx] && oPc[PC_TONE]) ? toneLin
                             : 14'sd0;
  wire signed [13:0] oMix  = clip14(confSum[oIdx] - 18'(ownF[outParty])
                                    + 18'(oTone));
  wire signed [15:0] oGain = scale(oMix, CONF_GAIN[oPc[6:5]]);
  wire signed [13:0] chIn  = chLinear ? chData : expand(chData[7:0]);
  wire signed [15:0] chMul = scale(chIn, lvlGain(chLevel));
  wire [7:0]  chOut = (!chLinear && chLevel == LVL_UNITY) ? chData[7:0]
                    : (chLevel == LVL_MUTE) ? compress(14'sd0, lawLim)
                    : compress(clip14(18'(chMul)), lawLim);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      outValid <= 1'b0;
      outLin   <= 14'sd0;
      chValid  <= 1'b0;
      chPcm    <= 8'h00;
    end else begin
      outValid <= outReq;
      chValid  <= chReq;
      if (outReq) outLin <= (oPc[2:0] == 3'd0) ? 14'sd0
                            : clip14(18'(oGain));
      if (chReq) chPcm <= chOut;
    end
  end

  generate
    for (p = 0; p < 16; p++) begin : g_map
      assign driveSlot[p]  = connect_map_high[p][CMH_DRIVE];
      assign delayConst[p] = connect_map_high[p][CMH_DELAY];
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rdData <= 8'h00;
    else if (!rdEn) rdData <= 8'h00;
    else if (addr == A_BRIDGE) rdData <= bridgeCtrl;
    else if (addr == A_IRQST) rdData <= 8'({ovfFlag, 1'b0});
    else if (addr == A_IRQMASK) rdData <= irqMask;
    else if (addr == A_OVFID) rdData <= {5'd0, ovfId};
    else if (hitParty) rdData <= {1'b0, partyCtrl[wIdx]};
    else if (hitCml) rdData <= connect_map_low[wIdx];
    else if (hitCmh) rdData <= connect_map_high[wIdx];
    else rdData <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_ovf_set;
    ovfEvent |=> ovfFlag && (irq == irqMask[MASK_OVF]);
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow missed");
  property p_rd_clear;
    irqRd && !ovfEvent |=> !ovfFlag && !irq;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("flag kept");
  property p_mask_capture;
    ovfEvent && !irqMask[MASK_OVF] && ovfId == 3'd0 && !wrEn
      |=> ovfId == $past(newId) && !irq;
  endproperty
  a_mask_capture: assert property (p_mask_capture) else $error("no id");
  property p_id_hold;
    ovfId != 3'd0 && !idRd && !blkClr |=> $stable(ovfId);
  endproperty
  a_id_hold: assert property (p_id_hold) else $error("id changed");
  property p_lead;
    leadWr && wIdx != 4'd0 && partyCtrl[0][2:0] == wrId && !blkClr
      |=> partyCtrl[0][2:0] == 3'd0;
  endproperty
  a_lead: assert property (p_lead) else $error("party kept");
  property p_clear;
    blkClr |=> partyCtrl[0] == 7'd0 && ovfId == 3'd0 && !toneAct[0];
  endproperty
  a_clear: assert property (p_clear) else $error("not cleared");
  property p_tone_start;
    g_conf[0].toneGo && !blkClr |=> toneAct[0] ##1 toneAct[0];
  endproperty
  a_tone_start: assert property (p_tone_start) else $error("no tone");
  property p_bypass;
    chReq && !chLinear && chLevel == LVL_UNITY
      |=> chValid && chPcm == $past(chData[7:0]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("not bypassed");
  property p_null_out;
    outReq && oPc[2:0] == 3'd0 |=> outValid && outLin == 14'sd0;
  endproperty
  a_null_out: assert property (p_null_out) else $error("null party");
  c_overflow: cover property (ovfEvent ##1 irq);
  c_lead:     cover property (leadWr);
  c_tone:     cover property (outReq && oTone != 14'sd0);
endmodule : cgc_conference_gain

// [dv/cgc_host_model.sv]
// Purpose: Host model driving the register port of the bridge block
// Assumes: Strobes launched by NBA right after a rising edge
// Notes:   Released write data is inverted so stale values never match
`timescale 1ns/1ps
module cgc_host_model (
  input  wire logic                   clk_sys,
  output logic      [cgc_pkg::AW-1:0] addr,
  output logic      [7:0]             wrData,
  output logic                        wrEn,
  output logic                        rdEn
);
  import cgc_pkg::*;
  initial begin
    addr   = '0;
    wrData = '0;
    wrEn   = 1'b0;
    rdEn   = 1'b0;
  end
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr   <= a;
    wrData <= d;
    wrEn   <= 1'b1;
    @(posedge clk_sys);
    wrEn   <= 1'b0;
    wrData <= ~d;
  endtask : wr
  task automatic rd(input logic [8:0] a);
    @(posedge clk_sys);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk_sys);
    rdEn <= 1'b0;
    addr <= ~a;
  endtask : rd
  task automatic bridge(input logic [7:0] d);
    wr(A_BRIDGE, d);
  endtask : bridge
  task automatic tone(input logic [7:0] src);
    wr(A_CML0 + 9'h00F, src);
    wr(A_CMH0 + 9'h00F, {3'h0, LVL_UNITY});
  endtask : tone
  task automatic allow(input logic on);
    wr(A_IRQMASK, {6'h00, on, 1'b0});
  endtask : allow
  task automatic party(input logic [3:0] p, input logic [7:0] c);
    wr(A_CMH0 + 9'(p), 8'h00);
    wr(A_CML0 + 9'(p), {4'h0, p});
    wr(A_PARTY0 + 9'(p), c);
  endtask : party
  task automatic slot(input logic [3:0] i, input logic [7:0] d);
    wr(A_CMH0 + 9'(i), d);
  endtask : slot
endmodule : cgc_host_model

// [dv/cgc_conference_gain_bench.sv]
// Purpose: Self-checking bench for the conference gain block
// Assumes: Tone step shortened to 8 cycles
// Notes:   Results are matched against queues of expected values
`timescale 1ns/1ps
module cgc_conference_gain_bench;
  import cgc_pkg::*;
  typedef struct { bit ne; logic [15:0] v; } cgc_exp_t;
  logic               clk_sys = 1'b0;
  logic               rst_n = 1'b0;
  logic [8:0]         addr;
  logic [7:0]         wrData, rdData, inPcm, tonePcm, toneSrcAddr, chPcm;
  logic               wrEn, rdEn, irq, outValid, chValid;
  logic               rdPend = 1'b0;
  logic               frameStart, inValid, toneValid, outReq, chReq;
  logic               chLinear;
  logic [3:0]         inParty, outParty;
  logic [4:0]         chLevel;
  logic [13:0]        chData;
  logic signed [13:0] outLin;
  logic [15:0]        driveSlot, delayConst;
  logic [31:0]        seed = 32'hEEE97FAB;
  logic [31:0]        toneRnd = 32'hEEE97FAB;
  int                 fail_count = 0;
  int                 samples_checked = 0;
  cgc_exp_t           rdQ[$], outQ[$], chQ[$];
  always #20 clk_sys = ~clk_sys;
  initial begin
    {frameStart, inValid, outReq, chReq, chLinear} = '0;
    {inParty, outParty, inPcm, chLevel, chData} = '0;
  end
  cgc_host_model host_i (.clk_sys(clk_sys), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn));
  cgc_conference_gain #(.TONE_STEP(8)) cgc_conference_gain_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .irq(irq),
    .frameStart(frameStart), .inValid(inValid), .inParty(inParty),
    .inPcm(inPcm), .toneValid(toneValid), .tonePcm(tonePcm),
    .toneSrcAddr(toneSrcAddr), .outReq(outReq), .outParty(outParty),
    .outValid(outValid), .outLin(outLin), .chReq(chReq),
    .chLevel(chLevel), .chLinear(chLinear), .chData(chData),
    .chValid(chValid), .chPcm(chPcm), .driveSlot(driveSlot),
    .delayConst(delayConst));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Random tone source samples; every code expands to a nonzero level
  always @(posedge clk_sys) begin
    toneRnd   <= lfsr(toneRnd);
    toneValid <= toneRnd[0];
    tonePcm   <= toneRnd[15:8];
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic check(input logic [15:0] s, input logic [15:0] e,
                       input bit ne);
    samples_checked++;
    if (ne ? (s === e || $isunknown(s)) : (s !== e)) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : wt
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    rdQ.push_back('{0, {8'h00, e}});
    host_i.rd(a);
  endtask : rd
  task automatic smp(input logic [3:0] p, input logic [7:0] d);
    @(posedge clk_sys);
    inValid <= 1'b1;
    inParty <= p;
    inPcm   <= d;
    @(posedge clk_sys);
    inValid <= 1'b0;
  endtask : smp
  task automatic frame;
    @(posedge clk_sys);
    frameStart <= 1'b1;
    @(posedge clk_sys);
    frameStart <= 1'b0;
  endtask : frame
  task automatic outq(input logic [3:0] p, input bit ne);
    outQ.push_back('{ne, 16'h0000});
    @(posedge clk_sys);
    outReq   <= 1'b1;
    outParty <= p;
    @(posedge clk_sys);
    outReq   <= 1'b0;
  endtask : outq
  task automatic chq(input logic [4:0] l, input logic lin,
                     input logic [13:0] d, input logic [7:0] e, bit ne);
    chQ.push_back('{ne, {8'h00, e}});
    @(posedge clk_sys);
    chReq    <= 1'b1;
    chLevel  <= l;
    chLinear <= lin;
    chData   <= d;
    @(posedge clk_sys);
    chReq    <= 1'b0;
  endtask : chq
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    rdPend <= rdEn;
    if (rdPend && rdQ.size() > 0) begin
      check({8'h00, rdData}, rdQ[0].v, 0);
      void'(rdQ.pop_front());
    end
    if (outValid && outQ.size() > 0) begin
      check(16'(outLin), 0, outQ[0].ne);
      void'(outQ.pop_front());
    end
    if (chValid && chQ.size() > 0) begin
      check({8'h00, chPcm}, chQ[0].v, chQ[0].ne);
      void'(chQ.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(A_BRIDGE, BC_RESET);
    rd(A_IRQMASK, MASK_RESET);
    rd(A_IRQST, 8'h00);
    rd(A_OVFID, 8'h00);
    rd(9'h1FF, 8'h00);
    host_i.slot(4'h2, 8'hC0);
    wt(1);
    check(driveSlot, 16'h0004, 0);
    check(delayConst, 16'h0004, 0);
    host_i.slot(4'h2, 8'h00);
    wt(1);
    check(driveSlot, 16'h0000, 0);
    host_i.bridge(8'h03);
    seed = lfsr(seed);
    host_i.tone(seed[7:0]);
    wt(1);
    check({8'h00, toneSrcAddr}, {8'h00, seed[7:0]}, 0);
    $display("test registers done");
    host_i.allow(1'b0);
    host_i.party(4'h0, 8'h0B);
    repeat (6) smp(4'h0, 8'h7F);
    frame();
    wt(2);
    check({15'h0, irq}, 16'h0000, 0);
    rd(A_IRQST, 8'h02);
    host_i.party(4'h1, 8'h0A);
    repeat (6) smp(4'h1, 8'h7F);
    frame();
    wt(2);
    rd(A_OVFID, 8'h03);
    rd(A_OVFID, 8'h00);
    rd(A_IRQST, 8'h02);
    rd(A_IRQST, 8'h00);
    host_i.allow(1'b1);
    repeat (6) smp(4'h1, 8'h7F);
    frame();
    wt(2);
    check({15'h0, irq}, 16'h0001, 0);
    rd(A_OVFID, 8'h02);
    rd(A_IRQST, 8'h02);
    wt(1);
    check({15'h0, irq}, 16'h0000, 0);
    $display("test overflow done");
    smp(4'h0, 8'h7F);
    frame();
    outq(4'h0, 0);
    host_i.party(4'h2, 8'h03);
    smp(4'h0, 8'h20);
    frame();
    outq(4'h2, 1);
    outq(4'h0, 0);
    host_i.party(4'h3, 8'h0B);
    smp(4'h0, 8'h20);
    frame();
    outq(4'h3, 0);
    outq(4'h2, 0);
    $display("test bridge done");
    host_i.party(4'h4, 8'h19);
    frame();
    outq(4'h4, 1);
    wt(20);
    frame();
    outq(4'h4, 0);
    $display("test tone done");
    host_i.party(4'h7, 8'h09);
    host_i.party(4'h8, 8'h01);
    host_i.bridge(8'h83);
    rd(A_BRIDGE, 8'h03);
    smp(4'h7, 8'h20);
    frame();
    outq(4'h8, 0);
    $display("test block reset done");
    for (int l = 0; l < 32; l++) chq(5'(l), 1'b1, 14'h0000, 8'h00, 0);
    repeat (8) begin
      seed = lfsr(seed);
      chq(LVL_UNITY, 1'b0, {6'h00, seed[7:0]}, seed[7:0], 0);
    end
    chq(LVL_MUTE, 1'b0, 14'h007F, 8'h00, 0);
    chq(5'h04, 1'b0, 14'h007F, 8'h7F, 1);
    chq(LVL_UNITY, 1'b1, 14'h1FFF, 8'h7F, 0);
    chq(LVL_UNITY, 1'b1, 14'(CLIP_MU), 8'h7F, 0);
    host_i.bridge(8'h13);
    chq(LVL_UNITY, 1'b1, 14'h1FFF, 8'h7F, 0);
    chq(LVL_UNITY, 1'b1, 14'h2000, 8'hFF, 0);
    $display("test gain done");
    wt(4);
    check(16'(rdQ.size() + outQ.size() + chQ.size()), 16'h0000, 0);
    close_out();
  end
endmodule : cgc_conference_gain_bench
